// File: nrc_pkg.sv
package nrc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COL_OUT_SETUP = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_CONFIRM = 8'he0;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROGRAM = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_COPY_PROGRAM = 8'h85;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;

  // ----------------------------------------------------------------
  // Identification addresses and lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] IDENT_ADDR_DEVICE = 8'h00;
  localparam logic [7:0] IDENT_ADDR_STANDARD = 8'h20;
  localparam int IDENT_LEN_DEVICE = 5;
  localparam int IDENT_LEN_STANDARD = 4;

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int COL_LO_MSB = 7;
  localparam int COL_HI_LSB = 8;
  localparam int COL_MSB = 11;
  localparam int ROW_LO_LSB = 0;
  localparam int ROW_HI_LSB = 8;
  localparam int ROW_MSB = 15;
  localparam int ADDR_CYCLES_FULL = 4;
  localparam int ADDR_CYCLES_COL = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STROBE_TIME_PS = 20000;
  localparam int STROBE_CYCLES = (STROBE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READY_SETTLE_PS = 100000;
  localparam int READY_SETTLE_CYCLES = (READY_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ARRAY_LOAD_TIME_PS = 25000000;
  localparam int ARRAY_LOAD_CYCLES = ARRAY_LOAD_TIME_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NRC_OP_PAGE_READ,
    NRC_OP_COL_READ,
    NRC_OP_IDENT,
    NRC_OP_STATUS,
    NRC_OP_RESET
  } nrc_op_t;

  typedef struct packed {
    nrc_op_t op;
    logic [COL_MSB:0] column;
    logic [ROW_MSB:0] row;
    logic [7:0] ident_addr;
    logic [12:0] count;
  } nrc_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } nrc_rdata_t;

endpackage : nrc_pkg

// File: nrc_fifo.sv
`timescale 1ns/10ps
module nrc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : nrc_fifo

// File: nrc_host.sv
`timescale 1ns/10ps
module nrc_host
  import nrc_pkg::*;
#(
  parameter int ARRAY_LOAD_CYC = ARRAY_LOAD_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Request port.
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire nrc_pkg::nrc_req_t REQ,
  // Read data stream.
  output logic RD_VALID,
  input wire logic RD_READY,
  output nrc_pkg::nrc_rdata_t RD,
  output logic BUSY,
  output logic TIMEOUT,
  // Flash pins.
  output logic CLE,
  output logic ALE,
  output logic CHIP_SEL_N,
  output logic WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic PROTECT_N,
  input wire logic READY_BUSY_N,
  input wire logic [7:0] IO_IN,
  output logic [7:0] IO_OUT,
  output logic IO_OE_N
);
  import nrc_pkg::*;
  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_WE_LOW, ST_WE_HIGH, ST_WAIT_RB, ST_RE_LOW, ST_RE_HIGH, ST_PUSH
  } nrc_state_t;
  typedef struct packed {
    logic is_cmd;
    logic [7:0] val;
  } nrc_step_t;
  // Returns one bus cycle of the selected operation; an index past its end repeats the last cycle.
  function automatic nrc_step_t step_of(nrc_req_t r, logic [3:0] i);
    nrc_step_t s;
    logic [7:0] col_hi;
    s = '{is_cmd: 1'b1, val: CMD_RESET};
    col_hi = {4'h0, r.column[COL_MSB:COL_HI_LSB]};
    case (r.op)
      NRC_OP_PAGE_READ: begin
        case (i)
          4'h0: s = '{1'b1, CMD_READ_SETUP};
          4'h1: s = '{1'b0, r.column[COL_LO_MSB:0]};
          4'h2: s = '{1'b0, col_hi};
          4'h3: s = '{1'b0, r.row[ROW_HI_LSB-1:ROW_LO_LSB]};
          4'h4: s = '{1'b0, r.row[ROW_MSB:ROW_HI_LSB]};
          default: s = '{1'b1, CMD_READ_CONFIRM};
        endcase
      end
      NRC_OP_COL_READ: begin
        case (i)
          4'h0: s = '{1'b1, CMD_COL_OUT_SETUP};
          4'h1: s = '{1'b0, r.column[COL_LO_MSB:0]};
          4'h2: s = '{1'b0, col_hi};
          default: s = '{1'b1, CMD_COL_OUT_CONFIRM};
        endcase
      end
      NRC_OP_IDENT: begin
        s = (i == 4'h0) ? nrc_step_t'{1'b1, CMD_READ_IDENT} : nrc_step_t'{1'b0, r.ident_addr};
      end
      NRC_OP_STATUS: s = '{1'b1, CMD_STATUS};
      default: s = '{1'b1, CMD_RESET};
    endcase
    return s;
  endfunction : step_of
  function automatic logic [3:0] steps_of(nrc_op_t op);
    case (op)
      NRC_OP_PAGE_READ: return 4'(2 + ADDR_CYCLES_FULL);
      NRC_OP_COL_READ: return 4'(2 + ADDR_CYCLES_COL);
      NRC_OP_IDENT: return 4'h2;
      default: return 4'h1;
    endcase
  endfunction : steps_of
  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [2:0] rb_sync_ff;
  logic rb_ff, nxt_rb;
  logic [7:0] io_s1_ff, io_s2_ff;
  always_comb begin
    nxt_rb = (rb_sync_ff[1] == rb_sync_ff[2]) ? rb_sync_ff[2] : rb_ff;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rb_sync_ff <= '0;
      rb_ff <= 1'b0;
      io_s1_ff <= '0;
      io_s2_ff <= '0;
    end else begin
      rb_sync_ff <= {rb_sync_ff[1:0], READY_BUSY_N};
      rb_ff <= nxt_rb;
      io_s1_ff <= IO_IN;
      io_s2_ff <= io_s1_ff;
    end
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  nrc_state_t st_ff, nxt_st;
  nrc_req_t req_ff, nxt_req;
  logic [3:0] idx_ff, nxt_idx;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [12:0] left_ff, nxt_left;
  logic cle_ff, nxt_cle, ale_ff, nxt_ale, we_n_ff, nxt_we_n, re_n_ff, nxt_re_n;
  logic oe_n_ff, nxt_oe_n, cs_n_ff, nxt_cs_n, tout_ff, nxt_tout;
  logic [7:0] io_ff, nxt_io, cap_ff, nxt_cap;
  logic f_in_ready;
  nrc_step_t cur;
  always_comb begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_idx = idx_ff;
    nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
    nxt_left = left_ff;
    nxt_cle = cle_ff;
    nxt_ale = ale_ff;
    nxt_we_n = we_n_ff;
    nxt_re_n = re_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_cs_n = cs_n_ff;
    nxt_io = io_ff;
    nxt_cap = cap_ff;
    nxt_tout = tout_ff;
    cur = step_of(req_ff, idx_ff);
    case (st_ff)
      ST_IDLE: begin
        nxt_cs_n = 1'b1;
        nxt_oe_n = 1'b1;
        if (REQ_VALID) begin
          nxt_req = REQ;
          nxt_idx = '0;
          nxt_left = REQ.count;
          nxt_tout = 1'b0;
          nxt_cs_n = 1'b0;
          nxt_st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Only status or reset go out while the device reports busy.
        if (rb_ff || req_ff.op == NRC_OP_STATUS || req_ff.op == NRC_OP_RESET) begin
          nxt_cle = cur.is_cmd;
          nxt_ale = !cur.is_cmd;
          nxt_io = cur.val;
          nxt_oe_n = 1'b0;
          nxt_we_n = 1'b0;
          nxt_tmr = 32'(STROBE_CYCLES);
          nxt_st = ST_WE_LOW;
        end
      end
      ST_WE_LOW: begin
        if (tmr_ff == '0) begin
          nxt_we_n = 1'b1;
          nxt_tmr = 32'(STROBE_CYCLES);
          nxt_st = ST_WE_HIGH;
        end
      end
      ST_WE_HIGH: begin
        if (tmr_ff == '0) begin
          nxt_cle = 1'b0;
          nxt_ale = 1'b0;
          nxt_oe_n = 1'b1;
          nxt_idx = idx_ff + 1'b1;
          if (idx_ff + 1'b1 != steps_of(req_ff.op)) begin
            nxt_st = ST_LOAD;
          end else if (req_ff.op == NRC_OP_PAGE_READ) begin
            // Busy is given time to fall before it is watched.
            nxt_tmr = 32'(READY_SETTLE_CYCLES + ARRAY_LOAD_CYC);
            nxt_st = ST_WAIT_RB;
          end else if (req_ff.op == NRC_OP_RESET || left_ff == '0) begin
            nxt_st = ST_IDLE;
          end else begin
            nxt_st = ST_RE_LOW;
          end
        end
      end
      ST_WAIT_RB: begin
        if (tmr_ff <= 32'(ARRAY_LOAD_CYC) && rb_ff) begin
          nxt_st = (left_ff == '0) ? ST_IDLE : ST_RE_LOW;
        end else if (tmr_ff == '0) begin
          nxt_tout = 1'b1;
          nxt_st = ST_IDLE;
        end
      end
      ST_RE_LOW: begin
        if (f_in_ready) begin
          nxt_re_n = 1'b0;
          nxt_tmr = 32'(STROBE_CYCLES);
          nxt_st = ST_RE_HIGH;
        end
      end
      ST_RE_HIGH: begin
        if (tmr_ff == '0 && !re_n_ff) begin
          nxt_cap = io_s2_ff;
          nxt_re_n = 1'b1;
          nxt_tmr = 32'(STROBE_CYCLES);
        end else if (tmr_ff == '0) begin
          nxt_left = left_ff - 1'b1;
          nxt_st = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // One strobe per byte; the device advances its column itself.
        nxt_st = (left_ff == '0) ? ST_IDLE : ST_RE_LOW;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= ST_IDLE;
      req_ff <= '0;
      idx_ff <= '0;
      tmr_ff <= '0;
      left_ff <= '0;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      io_ff <= '0;
      cap_ff <= '0;
      tout_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      idx_ff <= nxt_idx;
      tmr_ff <= nxt_tmr;
      left_ff <= nxt_left;
      cle_ff <= nxt_cle;
      ale_ff <= nxt_ale;
      we_n_ff <= nxt_we_n;
      re_n_ff <= nxt_re_n;
      oe_n_ff <= nxt_oe_n;
      cs_n_ff <= nxt_cs_n;
      io_ff <= nxt_io;
      cap_ff <= nxt_cap;
      tout_ff <= nxt_tout;
    end
  end
  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  nrc_fifo #(.WIDTH($bits(nrc_rdata_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(st_ff == ST_PUSH),
    .in_ready(f_in_ready),
    .in_data({cap_ff, left_ff == '0}),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data(RD)
  );
  assign REQ_READY = (st_ff == ST_IDLE);
  assign BUSY = !rb_ff;
  assign TIMEOUT = tout_ff;
  assign CLE = cle_ff;
  assign ALE = ale_ff;
  assign CHIP_SEL_N = cs_n_ff;
  assign WRITE_STROBE_N = we_n_ff;
  assign READ_STROBE_N = re_n_ff;
  // Program and erase are never issued by this controller, so protect stays asserted.
  assign PROTECT_N = 1'b0;
  assign IO_OUT = io_ff;
  assign IO_OE_N = oe_n_ff;

endmodule : nrc_host

// File: nrc_host_properties.sv
`timescale 1ns/10ps
module nrc_host_properties
  import nrc_pkg::*;
#(
  parameter int ARRAY_LOAD_CYC = 50,
  parameter int FIFO_DEPTH = 4
) (
  // Host side.
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire nrc_pkg::nrc_req_t REQ,
  input wire logic RD_VALID,
  input wire logic RD_READY,
  input wire nrc_pkg::nrc_rdata_t RD,
  input wire logic BUSY,
  input wire logic TIMEOUT,
  // Flash pins.
  input wire logic CLE,
  input wire logic ALE,
  input wire logic CHIP_SEL_N,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic PROTECT_N,
  input wire logic READY_BUSY_N,
  input wire logic [7:0] IO_IN,
  input wire logic [7:0] IO_OUT,
  input wire logic IO_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // Strobe pulses
  // ----------------------------------------------------------------
  sequence wr_held;
    (!WRITE_STROBE_N && !IO_OE_N && $stable(IO_OUT) && $stable(CLE) && $stable(ALE))[*4];
  endsequence
  sequence rd_held;
    (!READ_STROBE_N && IO_OE_N && !CLE && !ALE && !CHIP_SEL_N)[*4];
  endsequence
  latch_excl_a: assert property (!(CLE && ALE))
    else $error("Both latch enables high");
  latch_qual_a: assert property ($rose(WRITE_STROBE_N) |-> (CLE ^ ALE) && !CHIP_SEL_N)
    else $error("Write strobe rose with no latch enable");
  wr_hold_a: assert property ($fell(WRITE_STROBE_N) |-> ##1 wr_held)
    else $error("Write byte not held through strobe");
  rd_hold_a: assert property ($fell(READ_STROBE_N) |-> ##1 rd_held)
    else $error("Read strobe pulse malformed");
  strobe_excl_a: assert property (WRITE_STROBE_N || READ_STROBE_N)
    else $error("Read and write strobes low together");
  take_start_a: assert property (REQ_VALID && REQ_READY && !BUSY |=>
    !REQ_READY ##[0:3] $fell(WRITE_STROBE_N))
    else $error("Request taken without command write");
  busy_refuse_a: assert property ($fell(WRITE_STROBE_N) && BUSY |->
    CLE && (IO_OUT == CMD_STATUS || IO_OUT == CMD_RESET))
    else $error("Write strobe while busy was not status or reset");
  busy_track_a: assert property ($fell(READY_BUSY_N) |-> ##[1:5] BUSY)
    else $error("Busy not reported");
  ready_track_a: assert property ($rose(READY_BUSY_N) |-> ##[1:5] !BUSY)
    else $error("Ready not reported");
  protect_low_a: assert property (PROTECT_N == 1'b0)
    else $error("Protect released");
  rd_stream_a: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD))
    else $error("Read word dropped while stalled");
endmodule : nrc_host_properties

// File: nrc_nand_model.sv
`timescale 1ns/10ps
module nrc_nand_model #(
  parameter logic [39:0] DEV_ID = 40'h0,
  parameter logic [31:0] STD_ID = 32'h0
) (
  // Control pins.
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  // Data and status.
  input wire logic [7:0] io_in,
  output logic [7:0] io_drv,
  output logic ready_busy_n_n
);
  int busy_ns = 160;
  int n_bad = 0;
  int na = 0;
  int idx = 0;
  logic [7:0] mode = 8'h00;
  logic [7:0] adr [4];
  logic [15:0] row = 16'h0;
  logic [11:0] col = 12'h0;
  initial io_drv = 8'h00;
  initial ready_busy_n_n = 1'b1;
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (!(io_in inside {8'h00, 8'h30, 8'h05, 8'he0, 8'h90, 8'h70, 8'hff, 8'h80, 8'h10, 8'h85, 8'h60, 8'hd0})) begin
        n_bad++;
      end
      if (!ready_busy_n_n && !(io_in inside {8'h70, 8'hff})) n_bad++;
      if (io_in == 8'h30) begin
        row = {adr[3], adr[2]};
        col = {adr[1][3:0], adr[0]};
        ready_busy_n_n = 1'b0;
        ready_busy_n_n <= #(busy_ns) 1'b1;
      end
      if (io_in == 8'he0) col = {adr[1][3:0], adr[0]};
      if (io_in == 8'hff) begin
        ready_busy_n_n = 1'b0;
        ready_busy_n_n <= #40 1'b1;
      end
      // With protect low, program codes only park the mode and touch no data.
      mode = (io_in inside {8'h30, 8'he0, 8'hff}) ? 8'h00 : io_in;
      na = 0;
      idx = 0;
    end else if (!ce_n && ale) begin
      if (na == 1 && io_in[7:4] != 4'h0) n_bad++;
      if (na < 4) adr[na] = io_in;
      na++;
    end
  end
  always @(negedge re_n) begin
    if (!ce_n) begin
      case (mode)
        8'h90: io_drv = (adr[0] == 8'h20) ? STD_ID[31-8*idx -: 8] : DEV_ID[39-8*idx -: 8];
        8'h70: io_drv = ready_busy_n_n ? 8'he0 : 8'ha0;
        default: io_drv = row[7:0] ^ row[15:8] ^ col[7:0] ^ {4'h0, col[11:8]} ^ 8'h5a;
      endcase
    end
  end
  // A released bus shows the inverse of the last byte, so stale data never passes.
  always @(posedge re_n) begin
    io_drv = ~io_drv;
    col++;
    idx++;
  end
endmodule : nrc_nand_model

// File: nrc_host_tb_top.sv
`timescale 1ns/10ps
module nrc_host_tb_top;
  import nrc_pkg::*;
  // Arbitrary identification values.
  localparam logic [39:0] DEV_ID = 40'h3ca5006b00;
  localparam logic [31:0] STD_ID = 32'h21436587;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic RD_READY = 1'b0;
  nrc_req_t REQ = '0;
  logic REQ_READY, RD_VALID, BUSY, TIMEOUT, CLE, ALE, CHIP_SEL_N, WRITE_STROBE_N;
  logic READ_STROBE_N, PROTECT_N, IO_OE_N, READY_BUSY_N;
  nrc_rdata_t RD;
  logic [7:0] IO_OUT, IO_IN, m_drv;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  bit stall = 1'b0;
  assign IO_IN = IO_OE_N ? m_drv : IO_OUT;
  always #2 CLK = ~CLK;
  nrc_host #(.ARRAY_LOAD_CYC(50), .FIFO_DEPTH(4)) i_dut (
    .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RD_VALID(RD_VALID),
    .RD_READY(RD_READY), .RD(RD), .BUSY(BUSY), .TIMEOUT(TIMEOUT), .CLE(CLE), .ALE(ALE), .CHIP_SEL_N(CHIP_SEL_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N), .PROTECT_N(PROTECT_N),
    .READY_BUSY_N(READY_BUSY_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N));
  nrc_nand_model #(.DEV_ID(DEV_ID), .STD_ID(STD_ID)) i_model (
    .cle(CLE), .ale(ALE), .ce_n(CHIP_SEL_N), .we_n(WRITE_STROBE_N), .re_n(READ_STROBE_N),
    .wp_n(PROTECT_N), .io_in(IO_IN), .io_drv(m_drv), .ready_busy_n_n(READY_BUSY_N));
  always @(posedge CLK) begin
    #1;
    RD_READY = !stall && ($urandom_range(3) != 0);
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] exp_byte(int kind, logic [15:0] r, logic [11:0] c, int i);
    logic [11:0] k;
    k = c + 12'(i);
    case (kind)
      1: return DEV_ID[39-8*i -: 8];
      2: return STD_ID[31-8*i -: 8];
      3: return 8'he0;
      4: return 8'ha0;
      default: return r[7:0] ^ r[15:8] ^ k[7:0] ^ {4'h0, k[11:8]} ^ 8'h5a;
    endcase
  endfunction : exp_byte
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(nrc_op_t op, logic [11:0] c, logic [15:0] r, logic [7:0] ia, int n);
    int w = 0;
    #1;
    REQ = '{op: op, column: c, row: r, ident_addr: ia, count: 13'(n)};
    REQ_VALID = 1'b1;
    do begin
      @(posedge CLK);
      w++;
    end while (REQ_READY !== 1'b1 && w < 5000);
    #1;
    REQ_VALID = 1'b0;
  endtask : send
  task automatic take(int n, int kind, logic [15:0] r, logic [11:0] c);
    int w;
    for (int i = 0; i < n; i++) begin
      w = 0;
      do begin
        @(posedge CLK);
        w++;
      end while (!(RD_VALID === 1'b1 && RD_READY === 1'b1) && w < 3000);
      check("rd_data", 32'(RD.data), 32'(exp_byte(kind, r, c, i)));
      check("rd_last", 32'(RD.last), 32'(i == n - 1));
    end
  endtask : take
  task automatic page(logic [11:0] c, logic [15:0] r, int n);
    send(NRC_OP_PAGE_READ, c, r, 8'h00, n);
    take(n, 0, r, c);
    check("row_seen", 32'(i_model.row), 32'(r));
  endtask : page
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    int c;
    int r;
    int n;
    void'($urandom(32'hb544c1e9));
    repeat (4) @(posedge CLK);
    check("reset_pins", 32'({CHIP_SEL_N, WRITE_STROBE_N, READ_STROBE_N, IO_OE_N, BUSY}), 32'h1f);
    repeat (4) @(posedge CLK);
    #1;
    RST = 1'b0;
    @(posedge CLK);
    page(12'h000, 16'h0000, 3);
    page(12'h83e, 16'hffff, 2);
    // Stall the sink so the buffer fills and the host must park.
    stall = 1'b1;
    r = $urandom();
    c = $urandom_range(2000);
    send(NRC_OP_PAGE_READ, 12'(c), 16'(r), 8'h00, 8);
    repeat (500) @(posedge CLK);
    check("fifo_held", 32'({RD_VALID, READ_STROBE_N}), 32'h3);
    stall = 1'b0;
    take(8, 0, 16'(r), 12'(c));
    for (int k = 0; k < 2; k++) begin
      n = $urandom_range(2100);
      send(NRC_OP_COL_READ, 12'(n), 16'h0, 8'h00, 3);
      take(3, 0, 16'(r), 12'(n));
    end
    send(NRC_OP_IDENT, 12'h0, 16'h0, IDENT_ADDR_DEVICE, IDENT_LEN_DEVICE);
    take(IDENT_LEN_DEVICE, 1, 16'h0, 12'h0);
    send(NRC_OP_IDENT, 12'h0, 16'h0, IDENT_ADDR_STANDARD, IDENT_LEN_STANDARD);
    take(IDENT_LEN_STANDARD, 2, 16'h0, 12'h0);
    send(NRC_OP_STATUS, 12'h0, 16'h0, 8'h00, 1);
    take(1, 3, 16'h0, 12'h0);
    page(12'h7ff, 16'h1234, 2);
    send(NRC_OP_RESET, 12'h0, 16'h0, 8'h00, 0);
    @(posedge CLK);
    page(12'h010, 16'h0a0b, 1);
    repeat (6) begin
      r = $urandom();
      c = $urandom_range(2100);
      page(12'(c), 16'(r), $urandom_range(8, 1));
    end
    check("bad_wire", 32'(i_model.n_bad), 32'h0);
    // A slow array load must trip the host's ready watchdog.
    i_model.busy_ns = 2000;
    send(NRC_OP_PAGE_READ, 12'h0, 16'h0, 8'h00, 1);
    n = 0;
    while (TIMEOUT !== 1'b1 && n < 1000) begin
      @(posedge CLK);
      n++;
    end
    check("timeout_set", 32'(TIMEOUT), 32'h1);
    // The array is still loading, so only a status poll or a reset may go out now.
    send(NRC_OP_STATUS, 12'h0, 16'h0, 8'h00, 1);
    take(1, 4, 16'h0, 12'h0);
    repeat (800) @(posedge CLK);
    i_model.busy_ns = 160;
    page(12'h020, 16'h0101, 2);
    check("timeout_clear", 32'(TIMEOUT), 32'h0);
    tally_and_finish();
  end
endmodule : nrc_host_tb_top
bind nrc_host nrc_host_properties #(.ARRAY_LOAD_CYC(ARRAY_LOAD_CYC), .FIFO_DEPTH(FIFO_DEPTH)) i_props (
  .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RD_VALID(RD_VALID),
  .RD_READY(RD_READY), .RD(RD), .BUSY(BUSY), .TIMEOUT(TIMEOUT), .CLE(CLE), .ALE(ALE), .CHIP_SEL_N(CHIP_SEL_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N), .PROTECT_N(PROTECT_N),
  .READY_BUSY_N(READY_BUSY_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N));
